// ### hdl/mcf_decoder.sv
// Main-control execution of accumulator I/O, condition flags and character search
// Functional notes
// [RQ1] Word input loads 12-bit byte on narrow channel, full 24-bit word on wide.
// [RQ2] Accumulator cleared before input; narrow input leaves upper 12 bits zero.
// [RQ3] Accumulator I/O finishes with fetch three on; busy channel skips, fetch two on.
// [RQ4] Three-bit channel select picks one of eight; interrupt bit requests completion interrupt.
// [RQ5] Mode bits zero valid narrow; bit18 set, bit20 clear is plain transfer.
// [RQ6] Wide input assembly: mode 0 forward, mode 2 backward.
// [RQ7] Wide output disassembly: mode 2 forward, mode 0 backward.
// [RQ8] Character output sends accumulator low 6 bits, accumulator unchanged.
// [RQ9] Word output sends low 12 bits narrow or whole word wide; accumulator unchanged.
// [RQ10] Relocate-instruction-state clears flag 02; instruction state prefixes program references.
// [RQ11] Master clear leaves flag 02 cleared, same as relocate-instruction-state.
// [RQ12] Relocate-operand-state sets flag 02; operand state prefixes executive operand references.
// [RQ13] Set-boundary-jump sets flag 00.
// [RQ14] Next jump clears flag 00, enters program state, prefixes fetch; return jump store too.
// [RQ15] Condition-register access clears the boundary-jump flag.
// [RQ16] Interrupt to other processor held until that processor acknowledges it.
// [RQ17] Set-destructive-load sets flag 01.
// [RQ18] With flag 01, next load writes all ones back to memory and clears flag.
// [RQ19] Search starts when unit idle, fetch three on; busy unit, fetch two on.
// [RQ20] Search increments address comparing scan character; stops on match or limit.
// [RQ21] Current address kept in entry 20, limit in entry 30; entry 20 shows stop.
// [RQ22] Executive mode copies accumulator low three bits into entry 20 upper bits.
`timescale 1ns/100ps
module mcf_decoder
   import mcf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire mcf_cmd_t cmd_i,
   output logic cmd_ready_o,
   input wire logic exec_mode_i,
   input wire logic [STATE_W-1:0] isr_i,
   input wire logic [WORD_W-1:0] mem_data_i,
   output logic done_o,
   output logic [1:0] next_ofs_o,
   output logic [WORD_W-1:0] acc_o,
   input wire logic [NUM_CH-1:0] ch_busy_i,
   input wire logic [NUM_CH-1:0] ch_wide_i,
   input wire logic ch_ack_i,
   input wire logic [WORD_W-1:0] ch_data_i,
   output mcf_chan_t ch_o,
   output logic io_irq_o,
   output logic [2:0] cond_o,
   output logic enter_prog_o,
   output logic [STATE_W-1:0] jump_prefix_o,
   output logic prefix_store_o,
   output logic mem_wr_o,
   output logic [WORD_W-1:0] mem_wdata_o,
   output logic other_irq_o,
   input wire logic other_ack_i,
   output logic srch_rd_o,
   output logic [ADDR_W-1:0] srch_addr_o,
   input wire logic srch_ack_i,
   input wire logic [CHAR_W-1:0] srch_char_i,
   output logic srch_busy_o,
   output logic srch_done_o,
   output logic srch_irq_o,
   output logic [WORD_W-1:0] rf20_o,
   output logic [WORD_W-1:0] rf30_o
);
   typedef enum logic {ST_IDLE, ST_IO} mcf_st_t;
   typedef enum logic {SR_IDLE, SR_RUN} mcf_sr_t;

   mcf_st_t st_q, st_d;
   mcf_sr_t sr_q, sr_d;
   logic [WORD_W-1:0] acc_q, acc_d;
   logic [2:0] cond_q, cond_d;
   logic done_q, done_d;
   logic [1:0] ofs_q, ofs_d;
   mcf_chan_t ch_q, ch_d;
   logic int_q, int_d;
   logic irq_q, irq_d;
   logic enter_q, enter_d;
   logic [STATE_W-1:0] pfx_q, pfx_d;
   logic store_q, store_d;
   logic wr_q, wr_d;
   logic other_q, other_d;
   logic [WORD_W-1:0] rf20_q, rf20_d, rf30_q, rf30_d;
   logic [CHAR_W-1:0] scan_q, scan_d;
   logic neq_q, neq_d, sint_q, sint_d, sdone_q, sdone_d, sirq_q, sirq_d;
   logic take, is_io, plain, srch_start, at_limit, hit;
   assign take = cmd_valid_i && (st_q == ST_IDLE);
   assign is_io = cmd_i.op inside {OP_IN_WORD, OP_OUT_CHAR, OP_OUT_WORD};
   // Mode bit 18 set with bit 20 clear runs without assembly on either width
   assign plain = cmd_i.mode[0] && !cmd_i.mode[2]; // RQ5
   assign at_limit = rf20_q[ADDR_W-1:0] == rf30_q[ADDR_W-1:0];

   always_comb begin
      st_d = st_q;
      acc_d = acc_q;
      cond_d = cond_q;
      done_d = 1'b0;
      ofs_d = ofs_q;
      ch_d = ch_q;
      int_d = int_q;
      irq_d = 1'b0;
      enter_d = 1'b0;
      pfx_d = pfx_q;
      store_d = 1'b0;
      wr_d = 1'b0;
      // Acknowledge clears, a new request in the same cycle wins
      other_d = other_q && !other_ack_i; // RQ16
      srch_start = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (cmd_valid_i) begin
               done_d = 1'b1;
               ofs_d = OFS_NEXT;
               if (is_io) begin
                  if (ch_busy_i[cmd_i.chan]) begin // RQ4
                     ofs_d = OFS_BUSY; // RQ3
                  end else begin
                     done_d = 1'b0;
                     st_d = ST_IO;
                     int_d = cmd_i.int_req; // RQ4
                     ch_d.req = 1'b1;
                     ch_d.sel = cmd_i.chan; // RQ4
                     ch_d.write = cmd_i.op != OP_IN_WORD;
                     ch_d.wide = ch_wide_i[cmd_i.chan];
                     ch_d.assemble = ch_wide_i[cmd_i.chan] && !plain; // RQ5
                     ch_d.backward = ch_wide_i[cmd_i.chan] && !plain &&
                        ((cmd_i.op == OP_IN_WORD) ? (cmd_i.mode == ASM_BWD_IN) // RQ6
                                                  : (cmd_i.mode == DIS_BWD_OUT)); // RQ7
                     case (cmd_i.op)
                        OP_OUT_CHAR: ch_d.data = {18'h00000, acc_q[CHAR_W-1:0]}; // RQ8
                        OP_OUT_WORD: ch_d.data = ch_wide_i[cmd_i.chan] ? acc_q :
                           {12'h000, acc_q[BYTE_W-1:0]}; // RQ9
                        default: begin
                           ch_d.data = WORD_RST;
                           acc_d = WORD_RST; // RQ2
                        end
                     endcase
                  end
               end else begin
                  case (cmd_i.op)
                     OP_RELOC_IS: cond_d[CF_RELOC] = 1'b0; // RQ10
                     OP_RELOC_OS: cond_d[CF_RELOC] = 1'b1; // RQ12
                     OP_SET_BJ: cond_d[CF_BJ] = 1'b1; // RQ13
                     OP_SET_DL: cond_d[CF_DL] = 1'b1; // RQ17
                     OP_IRQ_OTHER: other_d = 1'b1; // RQ16
                     OP_COND_ACCESS: cond_d[CF_BJ] = 1'b0; // RQ15
                     OP_JUMP, OP_RET_JUMP: begin
                        if (cond_q[CF_BJ]) begin
                           cond_d[CF_BJ] = 1'b0; // RQ14
                           enter_d = 1'b1; // RQ14
                           pfx_d = isr_i; // RQ14
                           store_d = cmd_i.op == OP_RET_JUMP; // RQ14
                        end
                     end
                     OP_ACC_LOAD: begin
                        acc_d = mem_data_i;
                        if (cond_q[CF_DL]) begin
                           wr_d = 1'b1; // RQ18
                           cond_d[CF_DL] = 1'b0; // RQ18
                        end
                     end
                     OP_SRCH_EQ, OP_SRCH_NE: begin
                        if (sr_q != SR_IDLE) begin
                           ofs_d = OFS_BUSY; // RQ19
                        end else begin
                           srch_start = 1'b1; // RQ19
                           ofs_d = OFS_DONE; // RQ19
                        end
                     end
                     default: ;
                  endcase
               end
            end
         end
         ST_IO: begin
            if (ch_ack_i) begin
               st_d = ST_IDLE;
               ch_d.req = 1'b0;
               done_d = 1'b1;
               ofs_d = OFS_DONE; // RQ3
               irq_d = int_q; // RQ4
               if (!ch_q.write) begin
                  acc_d = ch_q.wide ? ch_data_i : {12'h000, ch_data_i[BYTE_W-1:0]}; // RQ1
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= ST_IDLE;
         acc_q <= WORD_RST;
         cond_q <= COND_RST; // RQ11
         done_q <= 1'b0;
         ofs_q <= OFS_NEXT;
         ch_q <= '0;
         int_q <= 1'b0;
         irq_q <= 1'b0;
         enter_q <= 1'b0;
         pfx_q <= 3'h0;
         store_q <= 1'b0;
         wr_q <= 1'b0;
         other_q <= 1'b0;
      end else begin
         st_q <= st_d;
         acc_q <= acc_d;
         cond_q <= cond_d;
         done_q <= done_d;
         ofs_q <= ofs_d;
         ch_q <= ch_d;
         int_q <= int_d;
         irq_q <= irq_d;
         enter_q <= enter_d;
         pfx_q <= pfx_d;
         store_q <= store_d;
         wr_q <= wr_d;
         other_q <= other_d;
      end
   end

   // Character compare; inequality search inverts the sense
   assign hit = (srch_char_i == scan_q) ^ neq_q; // RQ20
   always_comb begin
      sr_d = sr_q;
      rf20_d = rf20_q;
      rf30_d = rf30_q;
      scan_d = scan_q;
      neq_d = neq_q;
      sint_d = sint_q;
      sdone_d = 1'b0;
      sirq_d = 1'b0;
      case (sr_q)
         SR_IDLE: begin
            if (srch_start) begin
               sr_d = SR_RUN;
               rf20_d = WORD_RST;
               rf20_d[ADDR_W-1:0] = cmd_i.first; // RQ21
               // Program state number travels with the address, not via operand state
               if (exec_mode_i) begin
                  rf20_d[WORD_W-1:RF_STATE_LSB] = acc_q[STATE_W-1:0]; // RQ22
               end
               rf30_d = WORD_RST;
               rf30_d[ADDR_W-1:0] = cmd_i.limit; // RQ21
               scan_d = cmd_i.scan;
               neq_d = cmd_i.op == OP_SRCH_NE;
               sint_d = cmd_i.int_req;
            end
         end
         SR_RUN: begin
            if (at_limit) begin
               sr_d = SR_IDLE; // RQ20
               sdone_d = 1'b1;
               sirq_d = sint_q;
            end else if (srch_ack_i) begin
               if (hit) begin
                  sr_d = SR_IDLE; // RQ20
                  sdone_d = 1'b1;
                  sirq_d = sint_q;
               end else begin
                  rf20_d[ADDR_W-1:0] = rf20_q[ADDR_W-1:0] + 18'h00001; // RQ20
               end
            end
         end
         default: sr_d = SR_IDLE;
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sr_q <= SR_IDLE;
         rf20_q <= WORD_RST;
         rf30_q <= WORD_RST;
         scan_q <= 6'h00;
         neq_q <= 1'b0;
         sint_q <= 1'b0;
         sdone_q <= 1'b0;
         sirq_q <= 1'b0;
      end else begin
         sr_q <= sr_d;
         rf20_q <= rf20_d;
         rf30_q <= rf30_d;
         scan_q <= scan_d;
         neq_q <= neq_d;
         sint_q <= sint_d;
         sdone_q <= sdone_d;
         sirq_q <= sirq_d;
      end
   end
   assign cmd_ready_o = st_q == ST_IDLE;
   assign done_o = done_q;
   assign next_ofs_o = ofs_q;
   assign acc_o = acc_q;
   assign ch_o = ch_q;
   assign io_irq_o = irq_q;
   assign cond_o = cond_q; // RQ10
   assign enter_prog_o = enter_q;
   assign jump_prefix_o = pfx_q;
   assign prefix_store_o = store_q;
   assign mem_wr_o = wr_q;
   assign mem_wdata_o = DL_FILL; // RQ18
   assign other_irq_o = other_q;
   assign srch_rd_o = (sr_q == SR_RUN) && !at_limit;
   assign srch_addr_o = rf20_q[ADDR_W-1:0];
   assign srch_busy_o = sr_q != SR_IDLE;
   assign srch_done_o = sdone_q;
   assign srch_irq_o = sirq_q;
   assign rf20_o = rf20_q;
   assign rf30_o = rf30_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_io_start;
      take && is_io && !ch_busy_i[cmd_i.chan];
   endsequence
   sequence s_io_end;
      st_q == ST_IO && ch_ack_i;
   endsequence
   chk_busy_skip: assert property (take && is_io && ch_busy_i[cmd_i.chan] |=> // RQ3
      done_o && next_ofs_o == 2'h2 && st_q == ST_IDLE) else $error("busy channel not skipped");
   chk_io_finish: assert property (s_io_start ##1 s_io_end |=> // RQ3
      done_o && next_ofs_o == 2'h3 && !ch_o.req) else $error("I/O completion wrong");
   chk_narrow_input: assert property (s_io_end and (!ch_q.write && !ch_q.wide) |=> // RQ2
      acc_o[23:12] == 12'h000) else $error("narrow input left upper bits");
   chk_char_out: assert property (take && cmd_i.op == OP_OUT_CHAR && !ch_busy_i[cmd_i.chan]
      |=> ch_o.data == {18'h00000, $past(acc_q[5:0])} && acc_o == $past(acc_q)) // RQ8
      else $error("character output wrong");
   chk_reloc_clear: assert property (take && cmd_i.op == OP_RELOC_IS |=> !cond_o[2]) // RQ10
      else $error("relocation flag not cleared");
   chk_destr_load: assert property (take && cmd_i.op == OP_ACC_LOAD && cond_q[1] |=> // RQ18
      mem_wr_o && mem_wdata_o == 24'hffffff && !cond_o[1] && acc_o == $past(mem_data_i))
      else $error("destructive load wrong");
   chk_bj_jump: assert property (take && cmd_i.op == OP_RET_JUMP && cond_q[0] |=> // RQ14
      enter_prog_o && prefix_store_o && !cond_o[0] && jump_prefix_o == $past(isr_i))
      else $error("boundary jump wrong");
   chk_srch_busy: assert property (take && cmd_i.op inside {OP_SRCH_EQ, OP_SRCH_NE} &&
      srch_busy_o |=> next_ofs_o == 2'h2 && done_o) else $error("busy search not skipped"); // RQ19
   chk_other_hold: assert property (other_irq_o && !other_ack_i |=> other_irq_o) // RQ16
      else $error("other-processor interrupt dropped");
   chk_srch_limit: assert property (srch_busy_o && at_limit |=> // RQ20
      srch_done_o && !srch_busy_o && $stable(rf20_o)) else $error("search passed limit");
endmodule

// ### hdl/mcf_pkg.sv
// Shared constants and types for the main-control I/O, flag and search decoder
package mcf_pkg;
   localparam int ADDR_W = 18;
   localparam int WORD_W = 24;
   localparam int BYTE_W = 12;
   localparam int CHAR_W = 6;
   localparam int NUM_CH = 8;
   localparam int STATE_W = 3;
   // Fetch distance reported with each completed instruction
   localparam logic [1:0] OFS_NEXT = 2'h1;
   localparam logic [1:0] OFS_BUSY = 2'h2;
   localparam logic [1:0] OFS_DONE = 2'h3;
   // Condition flag bit positions
   localparam int CF_BJ = 0;
   localparam int CF_DL = 1;
   localparam int CF_RELOC = 2;
   localparam logic [2:0] COND_RST = 3'h0;
   localparam logic [WORD_W-1:0] DL_FILL = 24'hffffff;
   localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
   // Channel mode field, instruction bits 18..20
   localparam logic [2:0] ASM_BWD_IN = 3'h2;
   localparam logic [2:0] DIS_BWD_OUT = 3'h0;
   localparam int RF_STATE_LSB = WORD_W - STATE_W;

   typedef enum logic [3:0] {
      OP_NOP, OP_IN_WORD, OP_OUT_CHAR, OP_OUT_WORD, OP_RELOC_IS, OP_RELOC_OS,
      OP_SET_BJ, OP_SET_DL, OP_IRQ_OTHER, OP_JUMP, OP_RET_JUMP, OP_ACC_LOAD,
      OP_COND_ACCESS, OP_SRCH_EQ, OP_SRCH_NE
   } mcf_op_t;

   typedef struct packed {
      mcf_op_t op;
      logic [2:0] chan;
      logic int_req;
      logic [2:0] mode;
      logic [CHAR_W-1:0] scan;
      logic [ADDR_W-1:0] first;
      logic [ADDR_W-1:0] limit;
   } mcf_cmd_t;

   typedef struct packed {
      logic req;
      logic [2:0] sel;
      logic write;
      logic wide;
      logic assemble;
      logic backward;
      logic [WORD_W-1:0] data;
   } mcf_chan_t;
endpackage

// ### dv/mcf_chan_model.sv
// Behavioural data channel that answers transfer requests after a set delay
`timescale 1ns/100ps
module mcf_chan_model
   import mcf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire mcf_chan_t ch_i,
   input wire logic [3:0] lat_i,
   input wire logic [WORD_W-1:0] rdata_i,
   output logic ack_o,
   output logic [WORD_W-1:0] data_o,
   output mcf_chan_t seen_o
);
   int cnt;
   initial begin
      ack_o = 1'b0;
      data_o = WORD_RST;
      seen_o = '0;
      cnt = 0;
   end
   always @(posedge clk_i) begin
      #1;
      if (!rst_n_i || !ch_i.req || ack_o) begin
         cnt = 0;
         ack_o = 1'b0;
         // Released lines never keep the last word
         data_o = ~data_o;
      end else if (cnt >= lat_i) begin
         ack_o = 1'b1;
         data_o = rdata_i;
         seen_o = ch_i;
      end else begin
         cnt++;
         data_o = ~data_o;
      end
   end
endmodule

// ### dv/mcf_decoder_tb.sv
// Self-checking bench for the I/O, flag and search decoder
`timescale 1ns/100ps
module mcf_decoder_tb;
   import mcf_pkg::*;
   logic clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, exec_mode_i, done_o, ch_ack_i, io_irq_o;
   logic enter_prog_o, prefix_store_o, mem_wr_o, other_irq_o, other_ack_i, srch_rd_o;
   logic srch_busy_o, srch_done_o, srch_irq_o;
   logic srch_ack_i = 1'b0;
   logic [1:0] next_ofs_o;
   logic [2:0] cond_o, jump_prefix_o, isr_i;
   logic [3:0] lat;
   logic [5:0] srch_char_i = 6'h00;
   logic [7:0] ch_busy_i, ch_wide_i;
   logic [17:0] srch_addr_o;
   logic [23:0] mem_data_i, acc_o, ch_data_i, mem_wdata_o, rf20_o, rf30_o, rdata, acc_s;
   mcf_cmd_t cmd_i;
   mcf_chan_t ch_o, seen;
   int mismatches, cmp_count;

   mcf_decoder mcf_decoder_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .exec_mode_i(exec_mode_i), .isr_i(isr_i),
      .mem_data_i(mem_data_i), .done_o(done_o), .next_ofs_o(next_ofs_o), .acc_o(acc_o),
      .ch_busy_i(ch_busy_i), .ch_wide_i(ch_wide_i), .ch_ack_i(ch_ack_i), .ch_data_i(ch_data_i),
      .ch_o(ch_o), .io_irq_o(io_irq_o), .cond_o(cond_o), .enter_prog_o(enter_prog_o),
      .jump_prefix_o(jump_prefix_o), .prefix_store_o(prefix_store_o), .mem_wr_o(mem_wr_o),
      .mem_wdata_o(mem_wdata_o), .other_irq_o(other_irq_o), .other_ack_i(other_ack_i),
      .srch_rd_o(srch_rd_o), .srch_addr_o(srch_addr_o), .srch_ack_i(srch_ack_i),
      .srch_char_i(srch_char_i), .srch_busy_o(srch_busy_o), .srch_done_o(srch_done_o),
      .srch_irq_o(srch_irq_o), .rf20_o(rf20_o), .rf30_o(rf30_o));
   mcf_chan_model mcf_chan_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ch_i(ch_o),
      .lat_i(lat), .rdata_i(rdata), .ack_o(ch_ack_i), .data_o(ch_data_i), .seen_o(seen));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // Storage answers every other cycle; idle char line toggles
   always @(posedge clk_i) begin
      #1;
      srch_ack_i = srch_rd_o && !srch_ack_i;
      srch_char_i = srch_ack_i ? (srch_addr_o[5:0] ^ 6'h15) : ~srch_char_i;
   end

   task automatic test_done();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [WORD_W-1:0] s, input logic [WORD_W-1:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic run(input mcf_op_t op, input logic [2:0] c, input logic [2:0] md);
      int n;
      logic wt;
      n = 0;
      wt = (op inside {OP_IN_WORD, OP_OUT_CHAR, OP_OUT_WORD}) && !ch_busy_i[c];
      cmd_i.op = op;
      cmd_i.chan = c;
      cmd_i.mode = md;
      cmd_valid_i = 1'b1;
      @(posedge clk_i);
      #1 cmd_valid_i = 1'b0;
      // Non-I/O finish pulse stands only this one cycle
      chk("ready", cmd_ready_o, !wt);
      chk("done", done_o, !wt);
      while (done_o !== 1'b1 && n < 60) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (n >= 60) begin
         mismatches++;
         test_done();
      end
   endtask

   task automatic io(input mcf_op_t op, input logic [2:0] c, input logic [2:0] md,
                     input logic [23:0] e);
      logic w, bwd;
      w = ch_wide_i[c];
      bwd = w && !(md[0] && !md[2]) && (md == ((op == OP_IN_WORD) ? 3'h2 : 3'h0));
      acc_s = acc_o;
      run(op, c, md);
      chk("io ofs", next_ofs_o, OFS_DONE);
      chk("io irq", io_irq_o, cmd_i.int_req);
      chk("sel", seen.sel, c);
      chk("bwd", seen.backward, bwd);
      if (op == OP_IN_WORD) begin
         chk("acc in", acc_o, e);
      end else begin
         chk("out data", seen.data, e);
         chk("acc kept", acc_o, acc_s);
      end
   endtask

   task automatic t_io();
      cmd_i.int_req = 1'b1;
      io(OP_IN_WORD, 3'h3, 3'h0, 24'h000123);
      io(OP_IN_WORD, 3'h5, 3'h2, 24'habc123);
      io(OP_IN_WORD, 3'h5, 3'h1, 24'habc123);
      cmd_i.int_req = 1'b0;
      mem_data_i = 24'h5a5a3c;
      run(OP_ACC_LOAD, 3'h0, 3'h0);
      io(OP_OUT_WORD, 3'h1, 3'h0, 24'h000a3c);
      io(OP_OUT_WORD, 3'h5, 3'h0, 24'h5a5a3c);
      io(OP_OUT_WORD, 3'h5, 3'h2, 24'h5a5a3c);
      for (int c = 0; c < 8; c++) begin
         lat = c[3:0];
         io(OP_OUT_CHAR, c[2:0], 3'h0, 24'h00003c);
      end
      ch_busy_i = 8'h04;
      run(OP_IN_WORD, 3'h2, 3'h0);
      chk("busy ofs", next_ofs_o, OFS_BUSY);
      chk("busy acc", acc_o, 24'h5a5a3c);
      ch_busy_i = 8'h00;
      $display("test io done");
   endtask

   task automatic t_flags();
      run(OP_RELOC_OS, 3'h0, 3'h0);
      chk("reloc os", cond_o[CF_RELOC], 1'b1);
      run(OP_RELOC_IS, 3'h0, 3'h0);
      chk("reloc is", cond_o[CF_RELOC], 1'b0);
      run(OP_SET_BJ, 3'h0, 3'h0);
      chk("bj set", cond_o[CF_BJ], 1'b1);
      isr_i = 3'h6;
      run(OP_JUMP, 3'h0, 3'h0);
      chk("enter", enter_prog_o, 1'b1);
      chk("prefix", jump_prefix_o, 3'h6);
      chk("bj clr", cond_o[CF_BJ], 1'b0);
      run(OP_SET_BJ, 3'h0, 3'h0);
      run(OP_RET_JUMP, 3'h0, 3'h0);
      chk("store pfx", prefix_store_o, 1'b1);
      run(OP_SET_BJ, 3'h0, 3'h0);
      run(OP_COND_ACCESS, 3'h0, 3'h0);
      chk("cra clr", cond_o[CF_BJ], 1'b0);
      run(OP_JUMP, 3'h0, 3'h0);
      chk("plain jump", enter_prog_o, 1'b0);
      run(OP_SET_DL, 3'h0, 3'h0);
      chk("dl set", cond_o[CF_DL], 1'b1);
      mem_data_i = 24'h123456;
      run(OP_ACC_LOAD, 3'h0, 3'h0);
      chk("dl wr", mem_wr_o, 1'b1);
      chk("dl fill", mem_wdata_o, 24'hffffff);
      chk("dl acc", acc_o, 24'h123456);
      chk("dl clr", cond_o[CF_DL], 1'b0);
      run(OP_ACC_LOAD, 3'h0, 3'h0);
      chk("no wr", mem_wr_o, 1'b0);
      run(OP_IRQ_OTHER, 3'h0, 3'h0);
      repeat (3) @(posedge clk_i);
      #1 chk("irq held", other_irq_o, 1'b1);
      other_ack_i = 1'b1;
      @(posedge clk_i);
      #1 other_ack_i = 1'b0;
      chk("irq clr", other_irq_o, 1'b0);
      run(OP_RELOC_OS, 3'h0, 3'h0);
      rst_n_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      chk("mc cond", cond_o, COND_RST);
      $display("test flags done");
   endtask

   task automatic srch(input mcf_op_t op, input logic [17:0] f, input logic [17:0] l,
                       input logic [5:0] sc);
      cmd_i.first = f;
      cmd_i.limit = l;
      cmd_i.scan = sc;
      run(op, 3'h0, 3'h0);
      chk("srch ofs", next_ofs_o, OFS_DONE);
   endtask

   task automatic swait(input logic [17:0] stop, input logic [2:0] st);
      int n;
      n = 0;
      while (srch_done_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (n >= 400) begin
         mismatches++;
         test_done();
      end
      chk("stop", rf20_o[17:0], stop);
      chk("state", rf20_o[23:21], st);
      chk("limit", rf30_o[17:0], cmd_i.limit);
      chk("srch irq", srch_irq_o, cmd_i.int_req);
   endtask

   task automatic t_search();
      mem_data_i = 24'h000005;
      run(OP_ACC_LOAD, 3'h0, 3'h0);
      exec_mode_i = 1'b1;
      cmd_i.int_req = 1'b1;
      srch(OP_SRCH_EQ, 18'h00000, 18'h00040, 6'h3f);
      exec_mode_i = 1'b0;
      run(OP_SRCH_NE, 3'h0, 3'h0);
      chk("busy ofs", next_ofs_o, OFS_BUSY);
      chk("busy", srch_busy_o, 1'b1);
      swait(18'h0002a, 3'h5);
      cmd_i.int_req = 1'b0;
      srch(OP_SRCH_NE, 18'h00010, 18'h00020, 6'h05);
      swait(18'h00011, 3'h0);
      srch(OP_SRCH_EQ, 18'h00010, 18'h00014, 6'h30);
      swait(18'h00014, 3'h0);
      srch(OP_SRCH_EQ, 18'h00008, 18'h00008, 6'h1d);
      swait(18'h00008, 3'h0);
      $display("test search done");
   endtask

   initial begin
      mismatches = 0;
      cmp_count = 0;
      rst_n_i = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_i = '0;
      exec_mode_i = 1'b0;
      isr_i = 3'h0;
      mem_data_i = 24'h000000;
      ch_busy_i = 8'h00;
      ch_wide_i = 8'h20;
      other_ack_i = 1'b0;
      lat = 4'h2;
      rdata = 24'habc123;
      repeat (16) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      chk("rst ofs", next_ofs_o, OFS_NEXT);
      chk("rst cond", cond_o, COND_RST);
      t_io();
      t_flags();
      t_search();
      test_done();
   end
endmodule
